//--- inc/usp_consts.vh
// Constants for the three-channel serial pin-select unit
`ifndef USP_CONSTS_VH
`define USP_CONSTS_VH
// ---------------------------------------------------------------
// Register index within a channel (channel base = channel * 8)
// ---------------------------------------------------------------
`define USP_REG_MODE     3'h0
`define USP_REG_RATE     3'h1
`define USP_REG_TXBUF    3'h2
`define USP_REG_CTRL0    3'h3
`define USP_REG_CTRL1    3'h4
`define USP_REG_RXBUF    3'h5
`define USP_REG_PDIR     3'h6
`define USP_REG_PDAT     3'h7
// ---------------------------------------------------------------
// Global register
// ---------------------------------------------------------------
`define USP_ADDR_GLOBAL  5'h18
`define USP_GL_SEPFLOW   6
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define USP_MODE_UART8   3'h5
`define USP_MODE_CKEXT   3
`define USP_MODE_SLEEP   7
`define USP_C0_FSEL      2
`define USP_C0_FDIS      4
`define USP_C1_TXEN      0
`define USP_C1_TXEMPTY   1
`define USP_C1_RXEN      2
`define USP_C1_RXFULL    3
`define USP_C1_TXFULL    4
`define USP_C1_POLINV    5
`define USP_C1_DATINV    6
// ---------------------------------------------------------------
// Pin slots within a channel
// ---------------------------------------------------------------
`define USP_PIN_FLOW     0
`define USP_PIN_CLK      1
`define USP_PIN_RX       2
`define USP_PIN_TX       3
// ---------------------------------------------------------------
// Reset values and timing counts
// ---------------------------------------------------------------
`define USP_RST_BYTE     8'h00
`define USP_RST_CTRL0    8'h10
`define USP_RST_NIB      4'h0
`define USP_OS_LAST      4'hf
`define USP_OS_MID       4'h7
`define USP_BIT_LAST     3'h7
`endif

//--- rtl/usp_fifo2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module usp_fifo2 #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire             clk_sys_in,
	input  wire             srst_in,
	// Filling side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// Draining side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_q [0:1];
	reg             wr_ptr_q;
	reg             rd_ptr_q;
	reg [1:0]       count_q;
	wire            push;
	wire            pop;

	// Honest full and empty from the entry count
	assign in_ready_out  = (count_q != 2'd2);
	assign out_valid_out = (count_q != 2'd0);
	assign out_data_out  = mem_q[rd_ptr_q];
	assign push = in_valid_in & in_ready_out;
	assign pop  = out_valid_out & out_ready_in;

	// Storage and pointers
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'd0;
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= in_data_in;
				wr_ptr_q        <= ~wr_ptr_q;
			end
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			if (push & ~pop)
				count_q <= count_q + 2'd1;
			else if (pop & ~push)
				count_q <= count_q - 2'd1;
		end
	end
endmodule

//--- rtl/usp_serial_unit.v
// Three-channel serial unit: pin selection, inversion and sleep filter
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "usp_consts.vh"
module usp_serial_unit (
	// Clock and reset
	input  wire        clk_sys_in,
	input  wire        srst_in,
	// Register port
	input  wire [4:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [7:0]  reg_rdata_out,
	// Serial output pins, one per channel
	input  wire [2:0]  serial_out_pin_in,
	output wire [2:0]  serial_out_pin_out,
	output wire [2:0]  serial_out_pin_oe_out,
	// Serial input pins
	input  wire [2:0]  serial_in_pin_in,
	output wire [2:0]  serial_in_pin_out,
	output wire [2:0]  serial_in_pin_oe_out,
	// Transfer clock pins
	input  wire [2:0]  transfer_clock_pin_in,
	output wire [2:0]  transfer_clock_pin_out,
	output wire [2:0]  transfer_clock_pin_oe_out,
	// Flow-control pins
	input  wire [2:0]  flow_pin_in,
	output wire [2:0]  flow_pin_out,
	output wire [2:0]  flow_pin_oe_out,
	// Separate request pin of channel zero
	output reg         flow_alt_pin_out,
	output reg         flow_alt_pin_oe_out,
	// Receive completion pulses
	output wire [2:0]  rx_complete_out
);
	// ---------------------------------------------------------------
	// Local states
	// ---------------------------------------------------------------
	localparam [1:0] ST_IDLE  = 2'd0;
	localparam [1:0] ST_START = 2'd1;
	localparam [1:0] ST_DATA  = 2'd2;
	localparam [1:0] ST_STOP  = 2'd3;

	// Register select for one channel
	function reg_hit;
		input [4:0] addr;
		input [1:0] ch;
		input [2:0] idx;
		begin
			reg_hit = (addr == {ch, idx});
		end
	endfunction

	reg         sep_q;
	wire [23:0] ch_rdata;
	wire [2:0]  alt_rts_n;
	wire [2:0]  alt_sel;
	wire [11:0] pin_in_all;
	wire [11:0] pin_out_all;
	wire [11:0] pin_oe_all;

	// Gather pins into four slots per channel
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_pin
			assign pin_in_all[i*4+`USP_PIN_FLOW] = flow_pin_in[i];
			assign pin_in_all[i*4+`USP_PIN_CLK]  = transfer_clock_pin_in[i];
			assign pin_in_all[i*4+`USP_PIN_RX]   = serial_in_pin_in[i];
			assign pin_in_all[i*4+`USP_PIN_TX]   = serial_out_pin_in[i];
			assign flow_pin_out[i]       = pin_out_all[i*4+`USP_PIN_FLOW];
			assign flow_pin_oe_out[i]    = pin_oe_all[i*4+`USP_PIN_FLOW];
			assign transfer_clock_pin_out[i]    = pin_out_all[i*4+1];
			assign transfer_clock_pin_oe_out[i] = pin_oe_all[i*4+1];
			assign serial_in_pin_out[i]     = pin_out_all[i*4+`USP_PIN_RX];
			assign serial_in_pin_oe_out[i]  = pin_oe_all[i*4+`USP_PIN_RX];
			assign serial_out_pin_out[i]    = pin_out_all[i*4+`USP_PIN_TX];
			assign serial_out_pin_oe_out[i] = pin_oe_all[i*4+`USP_PIN_TX];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Per-channel logic
	// ---------------------------------------------------------------
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_ch
			localparam [1:0] CH = i;
			reg  [7:0] mode_q, rate_q, ctrl0_q, rxbuf_q, shrx_q, shtx_q;
			reg  [3:0] pdir_q, pdat_q, sync1_q, sync2_q, pout_q, poe_q;
			reg  [3:0] txen_q;
			reg        txen_unused;
			reg        tx_en_q, rx_en_q, pol_q, dinv_q, rxfull_q;
			reg        ck_prev_q, os_tick_q, txline_q, done_q;
			reg  [7:0] brg_cnt_q;
			reg  [1:0] tx_st_q, rx_st_q;
			reg  [3:0] tx_sub_q, rx_sub_q;
			reg  [2:0] tx_bit_q, rx_bit_q;
			wire       fifo_ready, fifo_valid, tx_pop;
			wire [7:0] fifo_data;
			wire       uart_on, ext_clk, sleep_on, fdis, sep_here;
			wire       cts_sel, rts_sel, rx_sel, ck_sel, data_inv;
			wire       rx_lvl, cts_lvl, ck_rise, src_tick, rts_n;
			wire       wr_tx, rd_rx, tx_go, rx_keep;
			reg  [7:0] rd_v;

			assign uart_on  = (mode_q[2:0] == `USP_MODE_UART8);
			assign ext_clk  = mode_q[`USP_MODE_CKEXT];
			assign sleep_on = mode_q[`USP_MODE_SLEEP] & (i != 2);
			assign data_inv = dinv_q & (i == 2);
			assign sep_here = sep_q & (i == 0);
			// Channel one loses flow control under separate pins
			assign fdis = ctrl0_q[`USP_C0_FDIS] | (sep_q & (i == 1));
			// Clear-to-send input on the flow pin
			assign cts_sel = uart_on & ~fdis & ~pdir_q[`USP_PIN_FLOW] &
				(sep_here | ~ctrl0_q[`USP_C0_FSEL]);
			// Request-to-send on the flow pin unless moved to its own pin
			assign rts_sel = uart_on & ~fdis & ctrl0_q[`USP_C0_FSEL] &
				~sep_here;
			assign alt_sel[i] = uart_on & ~fdis & sep_here;
			assign rx_sel  = uart_on & ~pdir_q[`USP_PIN_RX];
			assign ck_sel  = uart_on & ext_clk & ~pdir_q[`USP_PIN_CLK];
			// Sampled levels after the two-flop synchroniser
			assign rx_lvl  = rx_sel ? (sync2_q[`USP_PIN_RX] ^ pol_q) : 1'b1;
			assign cts_lvl = sync2_q[`USP_PIN_FLOW];
			assign ck_rise = sync2_q[`USP_PIN_CLK] & ~ck_prev_q;
			assign src_tick = ext_clk ? (ck_sel & ck_rise) : 1'b1;
			// Request-to-send low while receiver can take a character
			assign rts_n = ~(rx_en_q & ~rxfull_q);
			assign alt_rts_n[i] = rts_n;
			assign wr_tx = reg_wr_in & reg_hit(reg_addr_in, CH, `USP_REG_TXBUF);
			assign rd_rx = reg_rd_in & reg_hit(reg_addr_in, CH, `USP_REG_RXBUF);
			// Start condition of a transmission
			assign tx_go = (tx_st_q == ST_IDLE) & uart_on & tx_en_q &
				fifo_valid & (~cts_sel | ~cts_lvl);
			assign tx_pop = tx_go;
			// Sleep filter keeps only MSB-set characters
			assign rx_keep = ~sleep_on | shrx_q[7];
			assign rx_complete_out[i] = done_q;
			assign pin_out_all[i*4+3:i*4] = pout_q;
			assign pin_oe_all[i*4+3:i*4]  = poe_q;
			assign ch_rdata[i*8+7:i*8]    = rd_v;

			usp_fifo2 #(
				.WIDTH(8)
			) u_txfifo (
				.clk_sys_in    (clk_sys_in),
				.srst_in       (srst_in),
				.in_valid_in   (wr_tx),
				.in_ready_out  (fifo_ready),
				.in_data_in    (reg_wdata_in),
				.out_valid_out (fifo_valid),
				.out_ready_in  (tx_pop),
				.out_data_out  (fifo_data)
			);

			// Read view of this channel
			always @* begin
				rd_v = `USP_RST_BYTE;
				if (reg_hit(reg_addr_in, CH, `USP_REG_MODE))
					rd_v = mode_q;
				else if (reg_hit(reg_addr_in, CH, `USP_REG_RATE))
					rd_v = rate_q;
				else if (reg_hit(reg_addr_in, CH, `USP_REG_CTRL0))
					rd_v = ctrl0_q;
				else if (reg_hit(reg_addr_in, CH, `USP_REG_CTRL1))
					rd_v = {1'b0, dinv_q, pol_q, ~fifo_ready, rxfull_q,
						rx_en_q, ~fifo_valid, tx_en_q};
				else if (reg_hit(reg_addr_in, CH, `USP_REG_RXBUF))
					rd_v = rxbuf_q;
				else if (reg_hit(reg_addr_in, CH, `USP_REG_PDIR))
					rd_v = {4'h0, pdir_q};
				else if (reg_hit(reg_addr_in, CH, `USP_REG_PDAT))
					rd_v = {4'h0, sync2_q};
			end

			// Software registers of the channel
			always @(posedge clk_sys_in) begin
				if (srst_in) begin
					mode_q  <= `USP_RST_BYTE;
					rate_q  <= `USP_RST_BYTE;
					ctrl0_q <= `USP_RST_CTRL0;
					pdir_q  <= `USP_RST_NIB;
					pdat_q  <= `USP_RST_NIB;
					tx_en_q <= 1'b0;
					rx_en_q <= 1'b0;
					pol_q   <= 1'b0;
					dinv_q  <= 1'b0;
				end else if (reg_wr_in) begin
					if (reg_hit(reg_addr_in, CH, `USP_REG_MODE))
						mode_q <= reg_wdata_in;
					else if (reg_hit(reg_addr_in, CH, `USP_REG_RATE))
						rate_q <= reg_wdata_in;
					else if (reg_hit(reg_addr_in, CH, `USP_REG_CTRL0))
						ctrl0_q <= reg_wdata_in;
					else if (reg_hit(reg_addr_in, CH, `USP_REG_CTRL1)) begin
						tx_en_q <= reg_wdata_in[`USP_C1_TXEN];
						rx_en_q <= reg_wdata_in[`USP_C1_RXEN];
						pol_q   <= reg_wdata_in[`USP_C1_POLINV];
						dinv_q  <= reg_wdata_in[`USP_C1_DATINV];
					end else if (reg_hit(reg_addr_in, CH, `USP_REG_PDIR))
						pdir_q <= reg_wdata_in[3:0];
					else if (reg_hit(reg_addr_in, CH, `USP_REG_PDAT))
						pdat_q <= reg_wdata_in[3:0];
				end
			end

			// Pin synchroniser, clock edge and oversample divider
			always @(posedge clk_sys_in) begin
				if (srst_in) begin
					sync1_q   <= `USP_RST_NIB;
					sync2_q   <= `USP_RST_NIB;
					ck_prev_q <= 1'b0;
					brg_cnt_q <= `USP_RST_BYTE;
					os_tick_q <= 1'b0;
				end else begin
					sync1_q   <= pin_in_all[i*4+3:i*4];
					sync2_q   <= sync1_q;
					ck_prev_q <= sync2_q[`USP_PIN_CLK];
					os_tick_q <= src_tick & (brg_cnt_q == 8'h00);
					if (src_tick) begin
						if (brg_cnt_q == 8'h00)
							brg_cnt_q <= rate_q;
						else
							brg_cnt_q <= brg_cnt_q - 8'h01;
					end
				end
			end

			// Pin drivers: function or general I/O
			always @(posedge clk_sys_in) begin
				if (srst_in) begin
					pout_q <= `USP_RST_NIB;
					poe_q  <= `USP_RST_NIB;
				end else begin
					pout_q[`USP_PIN_TX] <= uart_on ? (txline_q ^ pol_q) :
						pdat_q[`USP_PIN_TX];
					poe_q[`USP_PIN_TX]  <= uart_on | pdir_q[`USP_PIN_TX];
					pout_q[`USP_PIN_RX] <= pdat_q[`USP_PIN_RX];
					poe_q[`USP_PIN_RX]  <= pdir_q[`USP_PIN_RX];
					pout_q[`USP_PIN_CLK] <= pdat_q[`USP_PIN_CLK];
					poe_q[`USP_PIN_CLK]  <= pdir_q[`USP_PIN_CLK];
					pout_q[`USP_PIN_FLOW] <= rts_sel ? rts_n :
						pdat_q[`USP_PIN_FLOW];
					poe_q[`USP_PIN_FLOW]  <= rts_sel | pdir_q[`USP_PIN_FLOW];
				end
			end

			// Transmitter: start, eight data bits LSB first, one stop
			always @(posedge clk_sys_in) begin
				if (srst_in) begin
					tx_st_q  <= ST_IDLE;
					tx_sub_q <= `USP_RST_NIB;
					tx_bit_q <= 3'h0;
					shtx_q   <= `USP_RST_BYTE;
					txline_q <= 1'b1;
				end else begin
					case (tx_st_q)
					ST_IDLE: begin
						txline_q <= 1'b1;
						tx_sub_q <= `USP_RST_NIB;
						if (tx_go) begin
							// Only character bits take the inversion
							shtx_q  <= fifo_data ^ {8{data_inv}};
							tx_st_q <= ST_START;
						end
					end
					ST_START: begin
						txline_q <= 1'b0;
						if (os_tick_q) begin
							tx_sub_q <= tx_sub_q + 4'h1;
							if (tx_sub_q == `USP_OS_LAST) begin
								tx_st_q  <= ST_DATA;
								tx_bit_q <= 3'h0;
							end
						end
					end
					ST_DATA: begin
						txline_q <= shtx_q[0];
						if (os_tick_q) begin
							tx_sub_q <= tx_sub_q + 4'h1;
							if (tx_sub_q == `USP_OS_LAST) begin
								shtx_q   <= {1'b0, shtx_q[7:1]};
								tx_bit_q <= tx_bit_q + 3'h1;
								if (tx_bit_q == `USP_BIT_LAST)
									tx_st_q <= ST_STOP;
							end
						end
					end
					default: begin
						txline_q <= 1'b1;
						if (os_tick_q) begin
							tx_sub_q <= tx_sub_q + 4'h1;
							if (tx_sub_q == `USP_OS_LAST)
								tx_st_q <= ST_IDLE;
						end
					end
					endcase
				end
			end

			// Receiver with receive buffer, and sleep filter on channels zero and one only
			always @(posedge clk_sys_in) begin
				if (srst_in) begin
					rx_st_q  <= ST_IDLE;
					rx_sub_q <= `USP_RST_NIB;
					rx_bit_q <= 3'h0;
					shrx_q   <= `USP_RST_BYTE;
					rxbuf_q  <= `USP_RST_BYTE;
					rxfull_q <= 1'b0;
					done_q   <= 1'b0;
				end else begin
					done_q <= 1'b0;
					// Read clears full; a new character in the same cycle wins
					if (rd_rx)
						rxfull_q <= 1'b0;
					if (os_tick_q) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						case (rx_st_q)
						ST_IDLE: begin
							rx_sub_q <= `USP_RST_NIB;
							if (uart_on & rx_en_q & ~rx_lvl)
								rx_st_q <= ST_START;
						end
						ST_START: begin
							if (rx_sub_q == `USP_OS_MID) begin
								rx_sub_q <= `USP_RST_NIB;
								rx_bit_q <= 3'h0;
								rx_st_q  <= rx_lvl ? ST_IDLE : ST_DATA;
							end
						end
						ST_DATA: begin
							if (rx_sub_q == `USP_OS_LAST) begin
								shrx_q   <= {rx_lvl, shrx_q[7:1]};
								rx_bit_q <= rx_bit_q + 3'h1;
								if (rx_bit_q == `USP_BIT_LAST)
									rx_st_q <= ST_STOP;
							end
						end
						default: begin
							if (rx_sub_q == `USP_OS_LAST) begin
								rx_st_q <= ST_IDLE;
								if (rx_keep) begin
									rxbuf_q  <= shrx_q ^ {8{data_inv}};
									rxfull_q <= 1'b1;
									done_q   <= 1'b1;
								end
							end
						end
						endcase
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Global register, separate request pin and read data
	// ---------------------------------------------------------------
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			sep_q               <= 1'b0;
			flow_alt_pin_out    <= 1'b1;
			flow_alt_pin_oe_out <= 1'b0;
			reg_rdata_out       <= `USP_RST_BYTE;
		end else begin
			if (reg_wr_in & (reg_addr_in == `USP_ADDR_GLOBAL))
				sep_q <= reg_wdata_in[`USP_GL_SEPFLOW];
			// Request-to-send of channel zero on its own pin
			flow_alt_pin_out    <= alt_sel[0] ? alt_rts_n[0] : 1'b1;
			flow_alt_pin_oe_out <= alt_sel[0];
			reg_rdata_out <= `USP_RST_BYTE;
			if (reg_rd_in) begin
				if (reg_addr_in == `USP_ADDR_GLOBAL)
					reg_rdata_out <= {1'b0, sep_q, 6'h00};
				else
					reg_rdata_out <= ch_rdata[7:0] | ch_rdata[15:8] |
						ch_rdata[23:16];
			end
		end
	end
endmodule

//--- tb/uart_pin_select_sleep_tb.sv
// Self-checking bench for the serial pin-select unit
`timescale 1ns/10ps
module uart_pin_select_sleep_tb;
	logic       clk_sys_in = 1'b0;
	logic       srst_in = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [2:0] fl_in = 3'h7;
	logic [2:0] ck_in = 3'h0;
	logic [1:0] pch = 2'h0;
	logic       pinv = 1'b0;
	logic [7:0] rxc1 = 8'h00;
	integer     error_cnt = 0;
	integer     n_compared = 0;
	wire  [7:0] rdata;
	wire  [2:0] so, so_oe, si_o, si_oe, ck_o, ck_oe, fl_o, fl_oe, rxc;
	wire        alt_o, alt_oe, peer_tx;
	// Wire levels: pull-up on released transmit lines
	wire  [2:0] tx_lines = so | ~so_oe;
	wire  [2:0] rx_lines = (si_oe & si_o) | (~si_oe & {3{peer_tx}});

	initial forever #4 clk_sys_in = ~clk_sys_in;

	usp_serial_unit u_dut (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
		.serial_out_pin_in(tx_lines), .serial_out_pin_out(so),
		.serial_out_pin_oe_out(so_oe),
		.serial_in_pin_in(rx_lines), .serial_in_pin_out(si_o),
		.serial_in_pin_oe_out(si_oe),
		.transfer_clock_pin_in((ck_oe & ck_o) | (~ck_oe & ck_in)),
		.transfer_clock_pin_out(ck_o), .transfer_clock_pin_oe_out(ck_oe),
		.flow_pin_in((fl_oe & fl_o) | (~fl_oe & fl_in)),
		.flow_pin_out(fl_o), .flow_pin_oe_out(fl_oe),
		.flow_alt_pin_out(alt_o), .flow_alt_pin_oe_out(alt_oe),
		.rx_complete_out(rxc));

	usp_peer u_peer (
		.clk_sys_in(clk_sys_in), .line_in(tx_lines[pch]),
		.inv_in(pinv), .line_out(peer_tx));

	// Count stores on channel one
	always @(posedge clk_sys_in) begin
		if (rxc[1] === 1'b1)
			rxc1 <= rxc1 + 8'h01;
	end

	// ----------------------------------------
	// Bus, compare and closing tasks
	// ----------------------------------------
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pk(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] e,
		input string nm);
		@(posedge clk_sys_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		#1 chk(nm, e, rdata);
	endtask
	task automatic take(input logic [7:0] e, input string nm);
		logic [7:0] v;
		v = 8'hxx;
		if (u_peer.got_q.size() != 0)
			v = u_peer.got_q.pop_front();
		chk(nm, e, v);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic summarize;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		error_cnt++;
		summarize;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		rchk(5'h03, 8'h10, "ctrl0 reset");
		rchk(5'h00, 8'h00, "mode reset");
		rchk(5'h19, 8'h00, "unmapped read");
		// Channel 0 UART, idle high before any transfer
		wr(5'h00, 8'h05);
		step(3);
		pk("tx idle", 1'b1, so[0] & so_oe[0]);
		// Clear-to-send high stalls; third byte refused
		wr(5'h03, 8'h00);
		wr(5'h04, 8'h01);
		wr(5'h02, 8'ha5);
		wr(5'h02, 8'h3c);
		wr(5'h02, 8'h81);
		step(200);
		pk("stalled line", 1'b1, so[0]);
		rchk(5'h04, 8'h11, "tx full flag");
		fl_in[0] <= 1'b0;
		step(400);
		take(8'ha5, "first byte");
		take(8'h3c, "second byte");
		pk("no third byte", 1'b1, u_peer.got_q.size() == 0);
		rchk(5'h04, 8'h03, "tx drained");
		// Flow and clock pins as general I/O
		wr(5'h03, 8'h10);
		wr(5'h06, 8'h03);
		wr(5'h07, 8'h02);
		step(3);
		pk("flow gpio oe", 1'b1, fl_oe[0]);
		pk("flow gpio out", 1'b0, fl_o[0]);
		pk("clk gpio oe", 1'b1, ck_oe[0]);
		pk("clk gpio out", 1'b1, ck_o[0]);
		wr(5'h06, 8'h00);
		// Channel 1 sleeping receiver with request-to-send
		wr(5'h08, 8'h85);
		wr(5'h0b, 8'h04);
		wr(5'h0c, 8'h04);
		step(3);
		pk("rts asserted", 1'b0, fl_o[1] | ~fl_oe[1]);
		u_peer.send(8'h35);
		step(40);
		chk("sleep drop", 8'h00, rxc1);
		rchk(5'h0c, 8'h06, "rx not full");
		u_peer.send(8'hb6);
		step(40);
		chk("wake store", 8'h01, rxc1);
		rchk(5'h0d, 8'hb6, "wake byte");
		// Channel 2 data inversion, then polarity inversion
		pch <= 2'h2;
		wr(5'h10, 8'h05);
		wr(5'h14, 8'h41);
		wr(5'h12, 8'h0f);
		step(200);
		take(8'hf0, "inverted data");
		pk("framing kept", 1'b1, u_peer.frame_ok);
		pinv <= 1'b1;
		wr(5'h14, 8'h21);
		step(3);
		pk("inverted idle", 1'b0, so[2]);
		wr(5'h12, 8'h5a);
		step(200);
		take(8'h5a, "polarity data");
		pk("inverted framing", 1'b1, u_peer.frame_ok);
		// Channel 2 on external clock: no pin edges, no progress
		pinv <= 1'b0;
		wr(5'h10, 8'h0d);
		wr(5'h14, 8'h01);
		wr(5'h12, 8'hc3);
		step(50);
		pk("ext clk stall", 1'b0, so[2]);
		repeat (340) begin
			ck_in[2] <= ~ck_in[2];
			step(2);
		end
		pk("ext clk idle", 1'b1, so[2]);
		rchk(5'h14, 8'h03, "ext clk drained");
		// Separate flow pins on channel 0
		wr(5'h18, 8'h40);
		wr(5'h03, 8'h00);
		step(3);
		pk("alt pin oe", 1'b1, alt_oe);
		pk("ch0 flow input", 1'b0, fl_oe[0]);
		pk("ch1 flow off", 1'b0, fl_oe[1]);
		summarize;
	end
endmodule

//--- tb/usp_peer.sv
// Remote serial peer: 8N1 sender and receiver, sixteen cycles a bit
`timescale 1ns/10ps
module usp_peer (
	// Clock and line
	input  wire clk_sys_in,
	input  wire line_in,
	input  wire inv_in,
	output reg  line_out
);
	localparam int BIT_T = 16;
	logic [7:0] got_q[$];
	logic       frame_ok;
	logic [7:0] sh;
	wire        ln = line_in ^ inv_in;

	initial line_out = 1'b1;

	// Sender: start low, LSB first, one stop high
	task automatic send(input logic [7:0] b);
		integer i;
		@(posedge clk_sys_in);
		line_out <= 1'b0;
		repeat (BIT_T) @(posedge clk_sys_in);
		for (i = 0; i < 8; i++) begin
			line_out <= b[i];
			repeat (BIT_T) @(posedge clk_sys_in);
		end
		line_out <= 1'b1;
		repeat (BIT_T) @(posedge clk_sys_in);
	endtask

	// Receiver: start checked at mid-bit, false starts dropped
	initial forever begin
		@(negedge ln);
		repeat (BIT_T / 2) @(posedge clk_sys_in);
		if (!ln) begin
			for (int k = 0; k < 8; k++) begin
				repeat (BIT_T) @(posedge clk_sys_in);
				sh[k] = ln;
			end
			repeat (BIT_T) @(posedge clk_sys_in);
			frame_ok = ln;
			got_q.push_back(sh);
		end
	end
endmodule

//--- tb/usp_serial_chk.sv
// Port-level checker for the serial pin-select unit
`timescale 1ns/10ps
module usp_serial_chk (
	// Clock, reset and register port
	input wire        clk_sys_in,
	input wire        srst_in,
	input wire [4:0]  reg_addr_in,
	input wire        reg_rd_in,
	input wire        reg_wr_in,
	input wire [7:0]  reg_rdata_out,
	// Pins and completion pulses
	input wire [2:0]  serial_out_pin_out,
	input wire [2:0]  serial_out_pin_oe_out,
	input wire [2:0]  serial_in_pin_oe_out,
	input wire [2:0]  transfer_clock_pin_oe_out,
	input wire [2:0]  flow_pin_out,
	input wire [2:0]  flow_pin_oe_out,
	input wire        flow_alt_pin_out,
	input wire        flow_alt_pin_oe_out,
	input wire [2:0]  rx_complete_out
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	reg  [7:0]  gap_q;
	wire [12:0] oe_all = {serial_out_pin_oe_out, serial_in_pin_oe_out,
		transfer_clock_pin_oe_out, flow_pin_oe_out, flow_alt_pin_oe_out};

	// Cycles since the last store on channel one, saturating
	always @(posedge clk_sys_in) begin
		if (srst_in)
			gap_q <= 8'hff;
		else if (rx_complete_out[1])
			gap_q <= 8'h00;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	end

	default clocking dflt_cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	// Assertions
	reset_quiet_a: assert property (disable iff (1'b0)
		srst_in |=> oe_all == 13'h0000 && rx_complete_out == 3'h0)
		else $error("pins driven during reset");
	read_data_idle_a: assert property (
		!reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data outside its cycle");
	unmapped_zero_a: assert property (
		reg_rd_in && reg_addr_in[4:3] == 2'h3 && reg_addr_in != 5'h18
		|=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	rx_pulse_a: assert property (
		rx_complete_out != 3'h0
		|=> (rx_complete_out & $past(rx_complete_out)) == 3'h0)
		else $error("completion pulse longer than one cycle");
	rx_spacing_a: assert property (
		rx_complete_out[1] |-> gap_q >= 8'h8c)
		else $error("stores closer than one frame");
	tx_idle_high_a: assert property (
		$rose(serial_out_pin_oe_out[0]) |=> serial_out_pin_out[0] [*3])
		else $error("transmit pin not idle high");
	bit_hold_a: assert property (
		$fell(serial_out_pin_out[0]) && serial_out_pin_oe_out[0]
		|=> !serial_out_pin_out[0] [*8])
		else $error("transmit low level too short");
	oe_by_write_a: assert property (
		$changed(oe_all) |-> $past(reg_wr_in) || $past(reg_wr_in, 2)
		|| $past(reg_wr_in, 3))
		else $error("pin direction changed without a write");
	rts_full_a: assert property (
		rx_complete_out[1] && flow_pin_oe_out[1] |-> ##[1:2] flow_pin_out[1])
		else $error("request-to-send not withdrawn when full");
	alt_idle_a: assert property (
		!flow_alt_pin_oe_out |-> flow_alt_pin_out)
		else $error("separate request pin not parked high");

	// Main scenarios reached
	store_c: cover property (rx_complete_out[1]);
	start_c: cover property ($fell(serial_out_pin_out[0]));
	alt_c: cover property (flow_alt_pin_oe_out);
endmodule

bind usp_serial_unit usp_serial_chk u_chk (
	.clk_sys_in(clk_sys_in), .srst_in(srst_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
	.reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
	.serial_out_pin_out(serial_out_pin_out),
	.serial_out_pin_oe_out(serial_out_pin_oe_out),
	.serial_in_pin_oe_out(serial_in_pin_oe_out),
	.transfer_clock_pin_oe_out(transfer_clock_pin_oe_out),
	.flow_pin_out(flow_pin_out), .flow_pin_oe_out(flow_pin_oe_out),
	.flow_alt_pin_out(flow_alt_pin_out),
	.flow_alt_pin_oe_out(flow_alt_pin_oe_out),
	.rx_complete_out(rx_complete_out));
